//--- rtl/port_pin_function_select.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - port2 pin1 code 00 data bit1, 01 echo two, 10 pwm1, 11 fourth_led_sink sink.
// - fourth_led_pwm_enable enable set modulates the fourth led sink with pwm.
// - port2 pin0 code 00 data bit0, 01 echo one, 10 pwm0, 11 third_led_sink sink.
// - third_led_pwm_enable enable set modulates the third led sink with pwm.
// - pcm data pad open-drain choice comes from its owning sub-block.
// - a selected sub-block function drives its pad without direction bits.
// - port3 bits 15-14, pin7: 00 data, 01 positive ring out; resets to 01.
// - port3 bits 13-12, pin6: 00 data, 01 negative ring out.
// - port3 bits 11-10, pin5: 00 data, 01 ringing detect or ring out.
// - port3 bits 9-8, pin4: 00 data, 01 parallel line detect.
// - port3 bits 7-6, pin3: 00 digital with adc off, 01 adc input.
// - port3 bits 5-4, pin2: 00 data, 01 positive caller id input.
// - port3 bits 3-2, pin1: data, amplifier plus, debug one, dcache probe.
// - port3 bits 1-0, pin0: data, amplifier minus, debug zero, icache probe.
module port_pin_function_select
  import pin_mux_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  echo_i,
  input  wire logic [1:0]  pwm_i,
  input  wire logic [1:0]  debug_i,
  input  wire logic        data_cache_hit_probe_i,
  input  wire logic        instruction_cache_hit_probe_i,
  input  wire logic        pcm_data_i,
  input  wire logic        pcm_od_i,
  input  wire logic [1:0]  p2_in_i,
  input  wire logic [7:0]  p3_in_i,
  output pad_drive_t [1:0] p2_pad_o,
  output pad_drive_t [7:0] p3_pad_o,
  output logic             adc_enable_o,
  output logic             pcm_out_o,
  output logic             pcm_oe_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [23:0] adr, input logic [23:0] off);
    hit = (adr[23:2] == off[23:2]);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[8*b +: 8] = dat[8*b +: 8];
      end
    end
  endfunction : merge

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0]  p2_out;
  logic [1:0]  p2_dir;
  logic [3:0]  p2_sel;
  logic [3:0]  pad_ctl;
  logic [7:0]  p3_out;
  logic [7:0]  p3_dir;
  logic [15:0] p3_sel;
  logic        wr;
  logic        rd;

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd) begin
      wb_dat_o <= 32'h0;
      if (hit(wb_adr_i, ADR_P2_OUT)) begin
        wb_dat_o <= {30'h0, p2_out};
      end
      if (hit(wb_adr_i, ADR_P3_OUT)) begin
        wb_dat_o <= {24'h0, p3_out};
      end
      if (hit(wb_adr_i, ADR_P2_SEL)) begin
        wb_dat_o <= {28'h0, p2_sel};
      end
      if (hit(wb_adr_i, ADR_PAD_CTL)) begin
        wb_dat_o <= {28'h0, pad_ctl};
      end
      if (hit(wb_adr_i, ADR_P2_DIR)) begin
        wb_dat_o <= {30'h0, p2_dir};
      end
      if (hit(wb_adr_i, ADR_P3_DIR)) begin
        wb_dat_o <= {24'h0, p3_dir};
      end
      if (hit(wb_adr_i, ADR_P3_SEL)) begin
        wb_dat_o <= {16'h0, p3_sel};
      end
      if (hit(wb_adr_i, ADR_PAD_IN)) begin
        wb_dat_o <= {16'h0, p3_in_i, 6'h0, p2_in_i};
      end
    end
  end

  // ----------------------------------------
  // port 2 registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p2_out  <= PORT_RESET[1:0];
      p2_dir  <= PORT_RESET[1:0];
      p2_sel  <= P2_SEL_RESET;
      pad_ctl <= PAD_CTL_RESET;
    end else if (wr) begin
      if (hit(wb_adr_i, ADR_P2_OUT)) begin
        p2_out <= 2'(merge({30'h0, p2_out}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, ADR_P2_DIR)) begin
        p2_dir <= 2'(merge({30'h0, p2_dir}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, ADR_P2_SEL)) begin
        p2_sel <= 4'(merge({28'h0, p2_sel}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, ADR_PAD_CTL)) begin
        pad_ctl <= 4'(merge({28'h0, pad_ctl}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ----------------------------------------
  // port 3 registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p3_out <= PORT_RESET;
      p3_dir <= PORT_RESET;
      p3_sel <= P3_SEL_RESET;
    end else if (wr) begin
      if (hit(wb_adr_i, ADR_P3_OUT)) begin
        p3_out <= 8'(merge({24'h0, p3_out}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, ADR_P3_DIR)) begin
        p3_dir <= 8'(merge({24'h0, p3_dir}, wb_dat_i, wb_sel_i));
      end
      if (hit(wb_adr_i, ADR_P3_SEL)) begin
        p3_sel <= 16'(merge({16'h0, p3_sel}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ----------------------------------------
  // port 2 pads
  // ----------------------------------------
  logic [1:0] od_bits;
  logic [1:0] pwm_en;
  assign od_bits = {pad_ctl[OD_PIN21_BIT], pad_ctl[OD_PIN20_BIT]};
  assign pwm_en  = {pad_ctl[FOURTH_LED_PWM_ENABLE_BIT], pad_ctl[THIRD_LED_PWM_ENABLE_BIT]};

  // pin0 echo one / pwm0 / third_led_sink, pin1 echo two / pwm1 / fourth_led_sink
  generate
    for (genvar i = 0; i < 2; i++) begin : g_p2
      pad_select_slice u_slice (
        .sel_i    (p2_sel[2*i +: 2]),
        .kinds_i  (P2_KINDS),
        .data_i   (p2_out[i]),
        .dir_i    (p2_dir[i]),
        .od_i     (od_bits[i]),
        .alt_i    ({1'b0, pwm_i[i], echo_i[i], 1'b0}),
        .pwm_en_i (pwm_en[i]),
        .pwm_i    (pwm_i[i]),
        .pad_o    (p2_pad_o[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // port 3 pads
  // ----------------------------------------
  generate
    for (genvar i = 0; i < 8; i++) begin : g_p3
      logic [3:0] alt;
      if (i == 1) begin : g_dc
        assign alt = {data_cache_hit_probe_i, debug_i[1], 2'h0};
      end else if (i == 0) begin : g_ic
        assign alt = {instruction_cache_hit_probe_i, debug_i[0], 2'h0};
      end else begin : g_an
        assign alt = 4'h0;
      end
      pad_select_slice u_slice (
        .sel_i    (p3_sel[2*i +: 2]),
        .kinds_i  ((i < 2) ? P3D_KINDS : P3A_KINDS),
        .data_i   (p3_out[i]),
        .dir_i    (p3_dir[i]),
        .od_i     (1'b0),
        .alt_i    (alt),
        .pwm_en_i (1'b0),
        .pwm_i    (1'b0),
        .pad_o    (p3_pad_o[i])
      );
    end
  endgenerate

  assign adc_enable_o = (p3_sel[7:6] == SEL_ALT1);

  // ----------------------------------------
  // pcm data pad
  // ----------------------------------------
  assign pcm_out_o = pcm_od_i ? 1'b0 : pcm_data_i;
  assign pcm_oe_o  = pcm_od_i ? ~pcm_data_i : 1'b1;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_p2_pin1_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (p2_sel[3:2] == SEL_ALT1 |-> p2_pad_o[1].out == echo_i[1] && p2_pad_o[1].oe) and
    (p2_sel[3:2] == SEL_ALT2 |-> p2_pad_o[1].out == pwm_i[1]))
    else $error("port2 pin1 decode wrong");

  a_p2_pin0_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (p2_sel[1:0] == SEL_DATA && p2_dir[0] && !od_bits[0] |-> p2_pad_o[0].out == p2_out[0]
      && p2_pad_o[0].oe) and
    (p2_sel[1:0] == SEL_ALT1 |-> p2_pad_o[0].out == echo_i[0]))
    else $error("port2 pin0 decode wrong");

  a_fourth_led_pwm_enable_sink: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_sel[3:2] == SEL_ALT3 |-> !p2_pad_o[1].oe &&
      p2_pad_o[1].sink == (pad_ctl[FOURTH_LED_PWM_ENABLE_BIT] ? pwm_i[1] : 1'b1))
    else $error("fourth_led_sink sink not as pwm control asks");

  a_third_led_pwm_enable_sink: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_sel[1:0] == SEL_ALT3 && pad_ctl[THIRD_LED_PWM_ENABLE_BIT] |-> p2_pad_o[0].sink == pwm_i[0])
    else $error("third_led_sink sink not modulated");

  a_pcm_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    pcm_od_i && pcm_data_i |-> !pcm_oe_o)
    else $error("pcm pad drives high in open drain");

  a_sub_drives_pad: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_sel[1] != p2_sel[0] && !p2_dir[0] |-> p2_pad_o[0].oe)
    else $error("sub-block pad not driven");

  a_p3_reset_ring: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> p3_sel == P3_SEL_RESET && p3_pad_o[7].analog)
    else $error("port3 select reset wrong");

  generate
    for (genvar i = 2; i < 8; i++) begin : g_chk
      a_p3_analog_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        p3_sel[2*i +: 2] == SEL_ALT1 |-> p3_pad_o[i].analog && !p3_pad_o[i].oe)
        else $error("port3 analog mode wrong");
      a_p3_reserved_data: assert property (@(posedge clk_i) disable iff (rst_i)
        p3_sel[2*i+1] |-> !p3_pad_o[i].analog && p3_pad_o[i].out == p3_out[i])
        else $error("reserved code not on data path");
    end
  endgenerate

  a_adc_select: assert property (@(posedge clk_i) disable iff (rst_i)
    p3_sel[7:6] == SEL_DATA |-> !adc_enable_o && p3_pad_o[3].out == p3_out[3])
    else $error("adc input not disabled");

  a_p3_pin1_probe: assert property (@(posedge clk_i) disable iff (rst_i)
    (p3_sel[3:2] == SEL_ALT2 |-> p3_pad_o[1].out == debug_i[1]) and
    (p3_sel[3:2] == SEL_ALT3 |-> p3_pad_o[1].out == data_cache_hit_probe_i))
    else $error("port3 pin1 decode wrong");

  a_p3_pin0_probe: assert property (@(posedge clk_i) disable iff (rst_i)
    (p3_sel[1:0] == SEL_ALT1 |-> p3_pad_o[0].analog) and
    (p3_sel[1:0] == SEL_ALT3 |-> p3_pad_o[0].out == instruction_cache_hit_probe_i))
    else $error("port3 pin0 decode wrong");

  a_sel_write_takes: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, ADR_P3_SEL) && wb_sel_i == 4'hf |=> p3_sel == $past(wb_dat_i[15:0]))
    else $error("port3 select write lost");

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule : port_pin_function_select
`default_nettype wire

//--- inc/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [23:0] ADR_P2_OUT  = 24'hff4850;
  localparam logic [23:0] ADR_P3_OUT  = 24'hff4854;
  localparam logic [23:0] ADR_P2_SEL  = 24'hff4858;
  localparam logic [23:0] ADR_PAD_CTL = 24'hff485c;
  localparam logic [23:0] ADR_P2_DIR  = 24'hff4860;
  localparam logic [23:0] ADR_P3_DIR  = 24'hff4864;
  localparam logic [23:0] ADR_P3_SEL  = 24'hff4868;
  localparam logic [23:0] ADR_PAD_IN  = 24'hff486c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int P2_PIN0_LSB   = 0;
  localparam int P2_PIN1_LSB   = 2;
  localparam int OD_PIN20_BIT  = 0;
  localparam int OD_PIN21_BIT  = 1;
  localparam int THIRD_LED_PWM_ENABLE_BIT  = 2;
  localparam int FOURTH_LED_PWM_ENABLE_BIT  = 3;
  localparam int PAD_IN_P3_LSB = 8;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0]  P2_SEL_RESET  = 4'h0;
  localparam logic [15:0] P3_SEL_RESET  = 16'h5555;
  localparam logic [3:0]  PAD_CTL_RESET = 4'h0;
  localparam logic [7:0]  PORT_RESET    = 8'h00;

  // ----------------------------------------
  // selection codes and pad kinds
  // ----------------------------------------
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_ALT3 = 2'h3;

  typedef enum logic [1:0] {
    KIND_DATA = 2'h0,
    KIND_DIG  = 2'h1,
    KIND_ANA  = 2'h2,
    KIND_LED  = 2'h3
  } pad_kind_t;

  typedef pad_kind_t [3:0] pin_kinds_t;

  localparam pin_kinds_t P2_KINDS  = {KIND_LED, KIND_DIG, KIND_DIG, KIND_DATA};
  localparam pin_kinds_t P3A_KINDS = {KIND_DATA, KIND_DATA, KIND_ANA, KIND_DATA};
  localparam pin_kinds_t P3D_KINDS = {KIND_DIG, KIND_DIG, KIND_ANA, KIND_DATA};

  typedef struct packed {
    logic out;
    logic oe;
    logic analog;
    logic sink;
  } pad_drive_t;

endpackage : pin_mux_pkg

//--- rtl/pad_select_slice.sv
`timescale 1ns/1ps
`default_nettype none
module pad_select_slice
  import pin_mux_pkg::*;
(
  input  wire logic [1:0] sel_i,
  input  wire pin_kinds_t kinds_i,
  input  wire logic       data_i,
  input  wire logic       dir_i,
  input  wire logic       od_i,
  input  wire logic [3:0] alt_i,
  input  wire logic       pwm_en_i,
  input  wire logic       pwm_i,
  output pad_drive_t      pad_o
);

  // ----------------------------------------
  // code to pad drive
  // ----------------------------------------
  always_comb begin
    pad_o = '0;
    unique case (kinds_i[sel_i])
      KIND_DATA: begin
        pad_o.out = data_i;
        pad_o.oe  = dir_i & (~od_i | ~data_i);
      end
      KIND_DIG: begin
        pad_o.out = alt_i[sel_i];
        pad_o.oe  = 1'b1;
      end
      KIND_ANA: begin
        pad_o.analog = 1'b1;
      end
      KIND_LED: begin
        pad_o.sink = pwm_en_i ? pwm_i : 1'b1;
      end
    endcase
  end

endmodule : pad_select_slice
`default_nettype wire

//--- bench/test_port_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_select
  import pin_mux_pkg::*;
;
  // ------------------------------
  // signals
  // ------------------------------
  logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, data_cache_hit_probe_i, instruction_cache_hit_probe_i;
  logic             pcm_data_i, pcm_od_i, wb_ack_o, adc_enable_o, pcm_out_o, pcm_oe_o;
  logic [23:0]      wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i, wb_dat_o, rd;
  logic [1:0]       echo_i, pwm_i, debug_i, p2_in_i;
  logic [7:0]       p3_in_i;
  pad_drive_t [1:0] p2_pad_o;
  pad_drive_t [7:0] p3_pad_o;
  pad_drive_t       got;
  int               fails = 0;
  int               tests_run = 0;

  typedef struct packed {
    logic       p3;
    logic [2:0] pin;
    logic [1:0] code;
    logic [3:0] exp;
  } row_t;

  // pad drive bits are out,oe,analog,sink
  localparam row_t ROWS [31] = '{
    '{1'h0, 3'h0, 2'h0, 4'h0}, '{1'h0, 3'h0, 2'h1, 4'h4}, '{1'h0, 3'h0, 2'h2, 4'hc},
    '{1'h0, 3'h0, 2'h3, 4'h1},
    '{1'h0, 3'h1, 2'h0, 4'h8}, '{1'h0, 3'h1, 2'h1, 4'hc}, '{1'h0, 3'h1, 2'h2, 4'h4},
    '{1'h0, 3'h1, 2'h3, 4'h1},
    '{1'h1, 3'h7, 2'h0, 4'h8}, '{1'h1, 3'h7, 2'h1, 4'h2}, '{1'h1, 3'h7, 2'h2, 4'h8},
    '{1'h1, 3'h7, 2'h3, 4'h8},
    '{1'h1, 3'h6, 2'h0, 4'h0}, '{1'h1, 3'h6, 2'h1, 4'h2},
    '{1'h1, 3'h5, 2'h0, 4'h8}, '{1'h1, 3'h5, 2'h1, 4'h2},
    '{1'h1, 3'h4, 2'h0, 4'h0}, '{1'h1, 3'h4, 2'h1, 4'h2},
    '{1'h1, 3'h3, 2'h0, 4'h0}, '{1'h1, 3'h3, 2'h1, 4'h2},
    '{1'h1, 3'h2, 2'h0, 4'hc}, '{1'h1, 3'h2, 2'h1, 4'h2}, '{1'h1, 3'h2, 2'h2, 4'hc},
    '{1'h1, 3'h1, 2'h0, 4'h4}, '{1'h1, 3'h1, 2'h1, 4'h2}, '{1'h1, 3'h1, 2'h2, 4'hc},
    '{1'h1, 3'h1, 2'h3, 4'hc},
    '{1'h1, 3'h0, 2'h0, 4'hc}, '{1'h1, 3'h0, 2'h1, 4'h2}, '{1'h1, 3'h0, 2'h2, 4'h4},
    '{1'h1, 3'h0, 2'h3, 4'h4}
  };

  port_pin_function_select u_port_pin_function_select (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .echo_i(echo_i), .pwm_i(pwm_i), .debug_i(debug_i),
    .data_cache_hit_probe_i(data_cache_hit_probe_i), .instruction_cache_hit_probe_i(instruction_cache_hit_probe_i), .pcm_data_i(pcm_data_i),
    .pcm_od_i(pcm_od_i), .p2_in_i(p2_in_i), .p3_in_i(p3_in_i), .p2_pad_o(p2_pad_o),
    .p3_pad_o(p3_pad_o), .adc_enable_o(adc_enable_o), .pcm_out_o(pcm_out_o), .pcm_oe_o(pcm_oe_o)
  );

  // ------------------------------
  // clock and tasks
  // ------------------------------
  always #5 clk_i = ~clk_i;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [23:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) chk("ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task automatic wr(input logic [23:0] adr, input logic [31:0] dat);
    wb(1'h1, adr, dat, 4'hf);
  endtask : wr

  task automatic rdc(input string name, input logic [23:0] adr, input logic [31:0] exp);
    wb(1'h0, adr, 32'h0, 4'hf);
    chk(name, exp, rd);
  endtask : rdc

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("unexpected watchdog expected finish seen timeout");
    final_report();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pcm_data_i, pcm_od_i} = 7'h22;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {echo_i, pwm_i, debug_i, data_cache_hit_probe_i, instruction_cache_hit_probe_i} = 8'h9a;
    p2_in_i = 2'h1;
    p3_in_i = 8'h3c;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(negedge clk_i);
    chk("adc at reset", 32'h1, {31'h0, adc_enable_o});
    chk("pin7 analog at reset", 32'h1, {31'h0, p3_pad_o[7].analog});
    rdc("p3 select reset", ADR_P3_SEL, 32'h5555);
    rdc("p2 select reset", ADR_P2_SEL, 32'h0);
    $display("test reset done");
    wr(ADR_P2_OUT, 32'h2);
    wr(ADR_P3_OUT, 32'ha5);
    wr(ADR_P2_DIR, 32'h0);
    wr(ADR_P3_DIR, 32'h07);
    wr(ADR_PAD_CTL, 32'h0);
    foreach (ROWS[i]) begin
      if (ROWS[i].p3) wr(ADR_P3_SEL, {30'h0, ROWS[i].code} << (2 * ROWS[i].pin));
      else wr(ADR_P2_SEL, {30'h0, ROWS[i].code} << (2 * ROWS[i].pin));
      @(negedge clk_i);
      got = ROWS[i].p3 ? p3_pad_o[ROWS[i].pin] : p2_pad_o[ROWS[i].pin[0]];
      chk($sformatf("pad row %0d", i), {28'h0, ROWS[i].exp}, {28'h0, got});
    end
    $display("test table done");
    wr(ADR_P2_SEL, 32'hf);
    wr(ADR_PAD_CTL, 32'hf);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      pwm_i <= k[1:0];
      @(negedge clk_i);
      chk("third_led_sink sink", {31'h0, k[0]}, {31'h0, p2_pad_o[0].sink});
      chk("fourth_led_sink sink", {31'h0, k[1]}, {31'h0, p2_pad_o[1].sink});
    end
    wr(ADR_PAD_CTL, 32'h3);
    @(posedge clk_i);
    pwm_i <= 2'h0;
    @(negedge clk_i);
    chk("led sinks steady", 32'h3, {30'h0, p2_pad_o[1].sink, p2_pad_o[0].sink});
    $display("test led done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      pcm_od_i <= k[1];
      pcm_data_i <= k[0];
      @(negedge clk_i);
      chk("pcm out", {31'h0, k[0] & ~k[1]}, {31'h0, pcm_out_o});
      chk("pcm oe", {31'h0, ~(k[1] & k[0])}, {31'h0, pcm_oe_o});
    end
    $display("test pcm done");
    wr(ADR_P3_SEL, 32'h0);
    @(negedge clk_i);
    chk("adc off", 32'h0, {31'h0, adc_enable_o});
    wb(1'h1, ADR_P3_SEL, 32'hffff, 4'h1);
    rdc("p3 select low lane", ADR_P3_SEL, 32'h00ff);
    wr(24'hff4870, 32'hffffffff);
    rdc("unmapped read", 24'hff4870, 32'h0);
    wr(ADR_PAD_IN, 32'hffffffff);
    rdc("pad in", ADR_PAD_IN, 32'h3c01);
    $display("test bus done");
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc("p3 select after reset", ADR_P3_SEL, 32'h5555);
    rdc("p2 select after reset", ADR_P2_SEL, 32'h0);
    $display("test reset again done");
    final_report();
  end
endmodule : test_port_pin_function_select
`default_nettype wire
